// ===== loop_disk_defines.svh
// What this block does
// (R01) Single mode: one loop address exposes the whole memory as one unit.
// (R02) Multiple mode: one loop device per 128K-byte section, each a cassette drive.
// (R03) Each section keeps own buffers and status; only one section active at once.
// (R04) Two 256-byte buffers: first to medium and loop, second loop only.
// (R05) One byte pointer 0..255 selects cells in both buffers, advancing per byte.
// (R06) Listener command 2: continuous recording, full first buffer overwrites record.
// (R07) Listener command 6: partial recording, load record, overwrite, write back, load next.
// (R08) Tracks of 256 records of 256 bytes; advance runs across track ends.
// (R09) Power-up or low-power recovery: first record, no mode, address undefined.
// (R10) Every received loop message is retransmitted unless its handling says otherwise.
// (R11) Interface Clear drops talker/listener and pending command, except device clear.
// (R12) Device clear, or selected clear as listener: first record, no mode, stop sending.
// (R13) Loop Power Down turns the device off and acts as a device clear.
// (R14) Matching listen address: leave talker, become listener; address 31 unlistens.
// (R15) Matching talk address: leave listener, become talker; other talk address: untalk.
// (R16) Unlisten clears listener, Untalk clears talker, Auto Address Unconfigure both.
// (R17) Ready for Command executes the pending command.
// (R18) Talker: Send Data starts data; Not Ready for Data ends after sent byte.
// (R19) Talker: Send Status gives one status byte, Send Accessory ID one class byte.
// (R20) Talker: Send Device ID gives eight ASCII bytes then carriage return, line feed.
// (R21) Talker: end-OK at end of data; end-ERROR at once on loop check failure.
// (R22) Auto Address: ignored if addressed or 31; else adopt, increment, forward.
`ifndef LOOP_DISK_DEFINES_SVH
`define LOOP_DISK_DEFINES_SVH

// ==========================================================
// frame classes (bits 10:8 of an 11-bit loop frame)
`define LD_CLS_CMD 3'h4
`define LD_CLS_RDY 3'h5

// ==========================================================
// command group
`define LD_IFC 8'h90
`define LD_DCL 8'h14
`define LD_SDC 8'h04
`define LD_LPD 8'h9B
`define LD_AAU 8'h9A
`define LD_UNL 8'h3F
`define LD_UNT 8'h5F
`define LD_GRP_LAD 3'h1
`define LD_GRP_TAD 3'h2
`define LD_GRP_DDL 3'h5

// ==========================================================
// ready group
`define LD_RFC 8'h00
`define LD_SDA 8'h60
`define LD_SST 8'h61
`define LD_SDI 8'h62
`define LD_SAI 8'h63
`define LD_NRD 8'h42
`define LD_ETO 8'h40
`define LD_ETE 8'h41
`define LD_GRP_AAD 3'h4
`define LD_ADDR_NONE 5'h1F

// ==========================================================
// listener command numbers
`define LD_DDL_WBUF0 5'h00
`define LD_DDL_WBUF1 5'h01
`define LD_DDL_WRITE 5'h02
`define LD_DDL_PWRITE 5'h06

// ==========================================================
// medium geometry and talker payloads
`define LD_SEG_REC_W 9
`define LD_LAST_CELL 8'hFF
`define LD_DEVID_LAST 4'h9
`define LD_ASCII_ZERO 8'h30
`define LD_ASCII_GOOD 8'h47
`define LD_ASCII_LOW 8'h4C
`define LD_ASCII_CR 8'h0D
`define LD_ASCII_LF 8'h0A
`define LD_STAT_IDLE 8'h00
`define LD_STAT_LOOP_ERR 8'h1F

`endif

// ===== loop_disk_pkg.sv
package loop_disk_pkg;
  typedef enum logic [1:0] {REC_NONE, REC_CONT, REC_PART} rec_mode_type;
  typedef enum logic [2:0] {SRC_BUF0, SRC_BUF1, SRC_DEVID, SRC_STAT, SRC_ACC} talk_src_type;
  typedef enum logic [1:0] {MED_IDLE, MED_LOAD, MED_STORE} med_state_type;
endpackage

// ===== loop_byte_store.sv
`timescale 1ns/100ps
`default_nettype none
// byte-wide flop storage, one write port, combinational read
module loop_byte_store #(
  parameter int AW = 10
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] cell_ff [2**AW];

  // data cells carry no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (we) begin
      cell_ff[waddr] <= wdata;
    end
  end

  assign rdata = cell_ff[raddr];
endmodule
`default_nettype wire

// ===== loop_ram_disk.sv
`timescale 1ns/100ps
`default_nettype none
`include "loop_disk_defines.svh"
module loop_ram_disk
  import loop_disk_pkg::*;
#(
  parameter int SEG_MAX = 4,
  parameter logic [47:0] ID_PREFIX = 48'h5241_4D44_534B, // arbitrary value
  parameter logic [7:0] ACC_ID = 8'h20, // arbitrary value
  localparam int SEC_W = (SEG_MAX > 1) ? $clog2(SEG_MAX) : 1,
  localparam int REC_W = SEC_W + `LD_SEG_REC_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // loop receive
  input wire logic rx_valid,
  input wire logic [10:0] rx_frame,
  output logic rx_ready,
  // loop retransmit
  output logic tx_valid,
  output logic [10:0] tx_frame,
  input wire logic tx_ready,
  // medium byte port
  output logic mem_req,
  output logic mem_we,
  output logic [REC_W+7:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // pins and straps
  input wire logic multi_mode_pin,
  input wire logic [SEC_W:0] seg_count_pin,
  input wire logic power_good_pin,
  input wire logic battery_low_pin,
  // status
  output logic powered_off,
  output logic is_listener,
  output logic is_talker
);
  // ==========================================================
  // parameter check
  if (SEG_MAX < 1 || SEG_MAX > 8 || (SEG_MAX & (SEG_MAX - 1)) != 0) begin : g_bad_seg
    $error("SEG_MAX must be a power of two from 1 to 8");
  end

  // ==========================================================
  // pin synchronisers and straps
  logic [SEC_W+3:0] pin_s1_ff, pin_s2_ff;
  logic pwr_ok_d_ff, multi_ff;
  logic [1:0] cap_cnt_ff;
  logic [SEC_W:0] segs_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {battery_low_pin, power_good_pin, multi_mode_pin, seg_count_pin};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // straps are caught once, after reset release and synchronising
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt_ff <= 2'h0;
      multi_ff <= 1'b0;
      segs_ff <= (SEC_W+1)'(1);
      pwr_ok_d_ff <= 1'b0;
    end else begin
      pwr_ok_d_ff <= pin_s2_ff[SEC_W+2];
      if (cap_cnt_ff != 2'h3) cap_cnt_ff <= cap_cnt_ff + 2'h1;
      if (cap_cnt_ff == 2'h2) begin
        multi_ff <= pin_s2_ff[SEC_W+1];
        segs_ff <= (pin_s2_ff[SEC_W:0] == '0) ? (SEC_W+1)'(1) : pin_s2_ff[SEC_W:0];
      end
    end
  end

  // ==========================================================
  // message decode
  logic lis_ff, tal_ff, talking_ff, pend_ok_ff, fin_ff, off_ff, wr_on_ff, aa_done_ff;
  logic [SEC_W-1:0] sec_ff, hit_sec;
  logic [4:0] pend_ff;
  logic [3:0] idx_ff, sel_idx;
  logic [7:0] ptr_ff, last_ff, cnt_ff, cur_byte, buf0_rd, buf1_rd;
  talk_src_type src_ff, data_sel_ff, new_src, sel_src;
  med_state_type mst_ff;
  logic [4:0] addr_ff [SEG_MAX];
  logic aok_ff [SEG_MAX];
  logic [REC_W-1:0] rec_ff [SEG_MAX];
  rec_mode_type mode_ff [SEG_MAX];
  logic chk_err_ff [SEG_MAX];
  logic [7:0] db;
  logic take, live, is_cmd, is_rdy, is_data, hit, restart, do_clr, exec, starting;
  logic send, lwr, cur_last, ld_start, st_start, adv, aa_go;
  logic [SEC_W:0] nsec;
  logic [5:0] aa_next;
  logic [REC_W-1:0] rec_abs, rec_inc, rec_lim;

  assign db = rx_frame[7:0];
  assign take = rx_valid && rx_ready;
  assign live = !off_ff;
  assign is_cmd = rx_frame[10:8] == `LD_CLS_CMD;
  assign is_rdy = rx_frame[10:8] == `LD_CLS_RDY;
  assign is_data = !rx_frame[10];
  assign nsec = multi_ff ? segs_ff : (SEC_W+1)'(1); // [R01] [R02]
  assign restart = pin_s2_ff[SEC_W+2] && !pwr_ok_d_ff; // [R09]
  assign do_clr = take && live && is_cmd &&
                  (db == `LD_DCL || db == `LD_LPD || (db == `LD_SDC && lis_ff)); // [R12] [R13]
  assign exec = take && live && is_rdy && db == `LD_RFC && pend_ok_ff; // [R17]
  assign starting = take && live && is_rdy && tal_ff &&
                    (db == `LD_SDA || db == `LD_SST || db == `LD_SDI || db == `LD_SAI);
  assign send = starting ||
                (take && live && is_data && talking_ff && db == last_ff && !fin_ff);
  assign lwr = take && live && is_data && lis_ff && wr_on_ff && !talking_ff;
  assign ld_start = exec && pend_ff == `LD_DDL_PWRITE; // [R07]
  assign st_start = lwr && data_sel_ff == SRC_BUF0 && ptr_ff == `LD_LAST_CELL &&
                    mode_ff[sec_ff] != REC_NONE; // [R06] [R07]
  assign aa_go = take && live && is_rdy && db[7:5] == `LD_GRP_AAD && !aa_done_ff &&
                 db[4:0] != `LD_ADDR_NONE; // [R22]
  assign aa_next = ({1'b0, db[4:0]} + 6'(nsec) > 6'h1F) ? 6'h1F : {1'b0, db[4:0]} + 6'(nsec);

  // address match over all sections; only one section is ever active
  always_comb begin
    hit = 1'b0;
    hit_sec = '0;
    for (int s = 0; s < SEG_MAX; s++) begin
      if (!hit && aok_ff[s] && addr_ff[s] == db[4:0]) begin
        hit = 1'b1;
        hit_sec = s[SEC_W-1:0]; // [R03]
      end
    end
  end

  // ==========================================================
  // talker byte source
  always_comb begin
    new_src = data_sel_ff;
    if (db == `LD_SST) new_src = SRC_STAT;
    if (db == `LD_SDI) new_src = SRC_DEVID;
    if (db == `LD_SAI) new_src = SRC_ACC;
    sel_src = starting ? new_src : src_ff;
    sel_idx = starting ? 4'h0 : idx_ff;
    cur_last = 1'b1;
    cur_byte = `LD_STAT_IDLE;
    unique case (sel_src)
      SRC_BUF0: begin
        cur_byte = buf0_rd;
        cur_last = ptr_ff == `LD_LAST_CELL;
      end
      SRC_BUF1: begin
        cur_byte = buf1_rd;
        cur_last = ptr_ff == `LD_LAST_CELL;
      end
      SRC_STAT: cur_byte = chk_err_ff[sec_ff] ? `LD_STAT_LOOP_ERR : `LD_STAT_IDLE; // [R19]
      SRC_ACC: cur_byte = ACC_ID; // [R19]
      SRC_DEVID: begin
        cur_last = sel_idx == `LD_DEVID_LAST; // [R20]
        if (sel_idx < 4'h6) cur_byte = ID_PREFIX[8'd47 - {sel_idx, 3'b000} -: 8];
        else if (sel_idx == 4'h6) cur_byte = `LD_ASCII_ZERO + 8'(segs_ff);
        else if (sel_idx == 4'h7) cur_byte = pin_s2_ff[SEC_W+3] ? `LD_ASCII_LOW : `LD_ASCII_GOOD;
        else if (sel_idx == 4'h8) cur_byte = `LD_ASCII_CR;
        else cur_byte = `LD_ASCII_LF;
      end
    endcase
  end

  // ==========================================================
  // loop protocol: roles, pending command, talker stream, retransmit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {lis_ff, tal_ff, talking_ff, pend_ok_ff, fin_ff, off_ff, wr_on_ff} <= '0;
      {tx_valid, rx_ready} <= '0;
      tx_frame <= 11'h000;
      sec_ff <= '0;
      pend_ff <= '0;
      idx_ff <= '0;
      last_ff <= '0;
      src_ff <= SRC_BUF0;
      data_sel_ff <= SRC_BUF0;
    end else begin
      rx_ready <= !take && mst_ff == MED_IDLE && (!tx_valid || tx_ready);
      if (tx_valid && tx_ready) tx_valid <= 1'b0;
      if (restart) begin
        {lis_ff, tal_ff, talking_ff, pend_ok_ff, off_ff, wr_on_ff} <= '0; // [R09]
      end else if (take) begin
        tx_valid <= 1'b1;
        tx_frame <= rx_frame; // [R10]
        if (do_clr) begin
          talking_ff <= 1'b0; // [R12]
          wr_on_ff <= 1'b0;
          if (db == `LD_LPD) {off_ff, lis_ff, tal_ff} <= 3'h4; // [R13]
        end
        if (!live) begin
          // powered down: only passes messages on
        end else if (is_cmd) begin
          if (db == `LD_IFC) begin
            {lis_ff, tal_ff, talking_ff, pend_ok_ff} <= '0; // [R11]
          end else if (db == `LD_AAU) begin
            {lis_ff, tal_ff, talking_ff} <= '0; // [R16]
          end else if (db == `LD_UNL) begin
            lis_ff <= 1'b0; // [R16]
          end else if (db == `LD_UNT) begin
            {tal_ff, talking_ff} <= '0; // [R16]
          end else if (db[7:5] == `LD_GRP_LAD) begin
            if (hit) begin
              lis_ff <= 1'b1; // [R14]
              {tal_ff, talking_ff} <= '0;
              sec_ff <= hit_sec; // [R03]
            end
          end else if (db[7:5] == `LD_GRP_TAD) begin
            if (hit) begin
              tal_ff <= 1'b1; // [R15]
              lis_ff <= 1'b0;
              sec_ff <= hit_sec;
            end else begin
              {tal_ff, talking_ff} <= '0; // [R15]
            end
          end else if (db[7:5] == `LD_GRP_DDL && lis_ff) begin
            pend_ok_ff <= 1'b1;
            pend_ff <= db[4:0];
          end
        end else if (is_rdy) begin
          if (exec) begin
            pend_ok_ff <= 1'b0; // [R17]
            wr_on_ff <= pend_ff == `LD_DDL_WBUF0 || pend_ff == `LD_DDL_WBUF1 ||
                        pend_ff == `LD_DDL_WRITE || pend_ff == `LD_DDL_PWRITE;
            if (pend_ff == `LD_DDL_WBUF1) data_sel_ff <= SRC_BUF1;
            else if (pend_ff != `LD_DDL_WBUF0 && pend_ff != `LD_DDL_WRITE &&
                     pend_ff != `LD_DDL_PWRITE) data_sel_ff <= data_sel_ff;
            else data_sel_ff <= SRC_BUF0;
          end
          if (starting) begin
            talking_ff <= 1'b1; // [R18] [R19] [R20]
            src_ff <= new_src;
          end
          if (db == `LD_NRD && talking_ff) talking_ff <= 1'b0; // [R18]
          if (aa_go) tx_frame <= {`LD_CLS_RDY, `LD_GRP_AAD, aa_next[4:0]}; // [R22]
        end else if (is_data && talking_ff) begin
          if (db != last_ff) begin
            tx_frame <= {`LD_CLS_RDY, `LD_ETE}; // [R21]
            talking_ff <= 1'b0;
          end else if (fin_ff) begin
            tx_frame <= {`LD_CLS_RDY, `LD_ETO}; // [R21]
            talking_ff <= 1'b0;
          end
        end
        if (send) begin
          tx_frame <= {3'h0, cur_byte}; // the echoed byte is checked on its return
          last_ff <= cur_byte;
          fin_ff <= cur_last;
          idx_ff <= sel_idx + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // byte pointer shared by both buffers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= 8'h00;
    end else if (restart || do_clr) begin
      ptr_ff <= 8'h00;
    end else if (lwr || (send && (sel_src == SRC_BUF0 || sel_src == SRC_BUF1))) begin
      ptr_ff <= ptr_ff + 8'h01; // [R05]
    end
  end

  // ==========================================================
  // auto addressing; the address stays undefined until assigned
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aa_done_ff <= 1'b0;
      for (int s = 0; s < SEG_MAX; s++) begin
        addr_ff[s] <= `LD_ADDR_NONE;
        aok_ff[s] <= 1'b0;
      end
    end else if (restart) begin
      aa_done_ff <= 1'b0; // [R09]
      for (int s = 0; s < SEG_MAX; s++) aok_ff[s] <= 1'b0;
    end else if (aa_go) begin
      aa_done_ff <= 1'b1; // [R22]
      for (int s = 0; s < SEG_MAX; s++) begin
        if (s < int'(nsec) && int'(db[4:0]) + s < 31) begin
          addr_ff[s] <= 5'(int'(db[4:0]) + s); // [R02]
          aok_ff[s] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // per-section record position, recording mode and status
  assign rec_abs = multi_ff ? {sec_ff, rec_ff[sec_ff][`LD_SEG_REC_W-1:0]} : rec_ff[sec_ff];
  assign rec_lim = multi_ff ? REC_W'(2**`LD_SEG_REC_W) : REC_W'(segs_ff) << `LD_SEG_REC_W;
  assign rec_inc = rec_ff[sec_ff] + REC_W'(1);
  assign adv = mst_ff == MED_STORE && mem_req && mem_ack && cnt_ff == `LD_LAST_CELL;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < SEG_MAX; s++) begin
        rec_ff[s] <= '0;
        mode_ff[s] <= REC_NONE;
        chk_err_ff[s] <= 1'b0;
      end
    end else begin
      for (int s = 0; s < SEG_MAX; s++) begin
        if (restart || (do_clr && (db != `LD_SDC || s == int'(sec_ff)))) begin
          rec_ff[s] <= '0; // [R09] [R12]
          mode_ff[s] <= REC_NONE;
          chk_err_ff[s] <= 1'b0;
        end else if (s == int'(sec_ff)) begin
          if (adv) rec_ff[s] <= (rec_inc == rec_lim) ? '0 : rec_inc; // [R08]
          if (exec && pend_ff == `LD_DDL_WRITE) mode_ff[s] <= REC_CONT; // [R06]
          if (exec && pend_ff == `LD_DDL_PWRITE) mode_ff[s] <= REC_PART; // [R07]
          if (exec && pend_ff == `LD_DDL_WBUF1 && mode_ff[s] == REC_PART) mode_ff[s] <= REC_NONE;
          if (take && is_data && talking_ff && db != last_ff) chk_err_ff[s] <= 1'b1; // [R21]
        end
      end
    end
  end

  // ==========================================================
  // medium transfer: one byte per request, request dropped between bytes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_ff <= MED_IDLE;
      cnt_ff <= 8'h00;
      {mem_req, mem_we} <= '0;
      mem_addr <= '0;
      mem_wdata <= 8'h00;
    end else if (mst_ff == MED_IDLE) begin
      cnt_ff <= 8'h00;
      if (ld_start) mst_ff <= MED_LOAD; // [R07]
      else if (st_start) mst_ff <= MED_STORE; // [R06]
    end else if (mem_req) begin
      if (mem_ack) begin
        mem_req <= 1'b0;
        cnt_ff <= cnt_ff + 8'h01;
        if (cnt_ff == `LD_LAST_CELL) begin
          // partial mode reloads the next record after each write-back
          mst_ff <= (mst_ff == MED_STORE && mode_ff[sec_ff] == REC_PART) ? MED_LOAD : MED_IDLE;
        end
      end
    end else begin
      mem_req <= 1'b1;
      mem_we <= mst_ff == MED_STORE;
      mem_addr <= {rec_abs, cnt_ff};
      mem_wdata <= buf0_rd;
    end
  end

  // ==========================================================
  // buffers, indexed by section so every section keeps its own pair
  logic buf0_we;
  logic [SEC_W+7:0] buf0_wa, buf0_ra;
  logic [7:0] buf0_wd;
  always_comb begin
    buf0_we = lwr && data_sel_ff == SRC_BUF0; // [R04]
    buf0_wa = {sec_ff, ptr_ff};
    buf0_wd = db;
    if (mst_ff == MED_LOAD && mem_req && mem_ack) begin
      buf0_we = 1'b1; // [R07]
      buf0_wa = {sec_ff, cnt_ff};
      buf0_wd = mem_rdata;
    end
    buf0_ra = (mst_ff == MED_IDLE) ? {sec_ff, ptr_ff} : {sec_ff, cnt_ff};
  end

  loop_byte_store #(.AW(SEC_W + 8)) u_buf0 (
    .clk(ref_clk),
    .we(buf0_we),
    .waddr(buf0_wa),
    .wdata(buf0_wd),
    .raddr(buf0_ra),
    .rdata(buf0_rd)
  );

  // second buffer talks to the loop only
  loop_byte_store #(.AW(SEC_W + 8)) u_buf1 (
    .clk(ref_clk),
    .we(lwr && data_sel_ff == SRC_BUF1), // [R04] [R03]
    .waddr({sec_ff, ptr_ff}),
    .wdata(db),
    .raddr({sec_ff, ptr_ff}),
    .rdata(buf1_rd)
  );

  assign powered_off = off_ff;
  assign is_listener = lis_ff;
  assign is_talker = tal_ff;
endmodule
`default_nettype wire

// ===== loop_ram_disk_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "loop_disk_defines.svh"
// ====
// loop and medium handshake checks
module loop_ram_disk_props #(
  parameter int SEG_MAX = 4,
  localparam int SEC_W = (SEG_MAX > 1) ? $clog2(SEG_MAX) : 1,
  localparam int REC_W = SEC_W + `LD_SEG_REC_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // loop
  input wire logic rx_valid,
  input wire logic [10:0] rx_frame,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [10:0] tx_frame,
  input wire logic tx_ready,
  // medium
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [REC_W+7:0] mem_addr,
  input wire logic mem_ack,
  // status
  input wire logic powered_off,
  input wire logic is_listener,
  input wire logic is_talker
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a command frame taken from the loop
  sequence took(logic [7:0] f);
    rx_valid && rx_ready && rx_frame == {`LD_CLS_CMD, f};
  endsequence
  // a medium byte finished that is not the last of its record
  sequence byte_done;
    mem_req && mem_ack && mem_addr[7:0] != `LD_LAST_CELL;
  endsequence
  take_answer_a: assert property (rx_valid && rx_ready |=> tx_valid && !rx_ready)
    else $error("taken frame not answered");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("retransmit frame dropped early");
  one_role_a: assert property (!(is_listener && is_talker))
    else $error("listener and talker at once");
  unl_clear_a: assert property (took(`LD_UNL) |-> ##[1:2] !is_listener)
    else $error("unlisten ignored");
  unt_clear_a: assert property (took(`LD_UNT) |-> ##[1:2] !is_talker)
    else $error("untalk ignored");
  ifc_clear_a: assert property (took(`LD_IFC) |-> ##[1:2] !(is_listener || is_talker))
    else $error("interface clear ignored");
  power_down_a: assert property (took(`LD_LPD) |-> ##[1:2] powered_off)
    else $error("power down ignored");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("medium request changed before ack");
  next_byte_a: assert property (byte_done |=> !mem_req ##1 mem_req)
    else $error("next medium byte not requested");
  byte_step_a: assert property (byte_done ##2 1'b1 |-> mem_addr[7:0] == $past(mem_addr[7:0], 2) + 8'h01)
    else $error("medium byte address did not step");
endmodule
bind loop_ram_disk loop_ram_disk_props #(.SEG_MAX(SEG_MAX)) props_inst (.ref_clk, .rst_n,
  .rx_valid, .rx_frame, .rx_ready, .tx_valid, .tx_frame, .tx_ready, .mem_req, .mem_we,
  .mem_addr, .mem_ack, .powered_off, .is_listener, .is_talker);
`default_nettype wire

// ===== loop_medium_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// medium model, answers alternate quick and slow
module loop_medium_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // byte port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [18:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] cells [int];
  logic [1:0] wait_ff;
  logic slow_ff;
  int n_wr;
  // data valid only with the ack pulse, inverted afterwards so stale data is caught
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      wait_ff <= 2'h0;
      slow_ff <= 1'b0;
      n_wr <= 0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_ff != {slow_ff, slow_ff}) begin
      wait_ff <= wait_ff + 2'h1;
    end else if (mem_req) begin
      mem_ack <= 1'b1;
      wait_ff <= 2'h0;
      slow_ff <= ~slow_ff;
      if (mem_we) begin
        cells[mem_addr] = mem_wdata;
        n_wr <= n_wr + 1;
      end else begin
        mem_rdata <= cells.exists(mem_addr) ? cells[mem_addr] : 8'hA5;
      end
    end
  end
endmodule
`default_nettype wire

// ===== loop_ram_disk_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "loop_disk_defines.svh"
module loop_ram_disk_tb;
  localparam logic [47:0] PFX = 48'h5445_5354_4944; // arbitrary value
  localparam logic [7:0] ACC = 8'h2A; // arbitrary value
  localparam logic [2:0] CMD = `LD_CLS_CMD;
  localparam logic [2:0] RDY = `LD_CLS_RDY;
  localparam logic [7:0] WR = {`LD_GRP_DDL, `LD_DDL_WRITE};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid = 1'b0;
  logic [10:0] rx_frame = 11'h000;
  logic tx_ready = 1'b0;
  logic battery_low_pin = 1'b1;
  logic power_good_pin = 1'b1;
  logic rx_ready, tx_valid, mem_req, mem_we, mem_ack, powered_off, is_listener, is_talker;
  logic [10:0] tx_frame;
  logic [18:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [10:0] q [$];
  logic [7:0] id [10];
  logic [7:0] dat [256];
  logic [31:0] lf = 32'hDB4E, rn = 32'hDB4E;
  int bad_count = 0, n_checks = 0, cyc = 0;
  loop_ram_disk #(.SEG_MAX(4), .ID_PREFIX(PFX), .ACC_ID(ACC)) loop_ram_disk_inst (.ref_clk,
    .rst_n, .rx_valid, .rx_frame, .rx_ready, .tx_valid, .tx_frame, .tx_ready, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .multi_mode_pin(1'b0),
    .seg_count_pin(3'h4), .power_good_pin, .battery_low_pin, .powered_off, .is_listener,
    .is_talker);
  loop_medium_model loop_medium_model_inst (.ref_clk, .rst_n, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always #10 ref_clk = ~ref_clk;
  // random stalls on the retransmit side
  always @(negedge ref_clk) begin
    lf <= lfsr(lf);
    tx_ready <= lf[0] | lf[3];
  end
  // each accepted retransmit frame against the oldest note
  always @(posedge ref_clk) begin
    if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      n_checks++;
      if (q.size() == 0 || tx_frame !== q[0]) begin
        bad_count++;
        $display("unexpected at %0t: frame %h", $time, tx_frame);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  task automatic test_done();
    bad_count += q.size(); // unanswered notes
    $display("mismatches %0d comparisons %0d", bad_count, n_checks);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // bound the run; a hang counts against it
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end
  // offer a frame and note the frame expected back; held until taken
  task automatic send(input logic [10:0] f, input logic [10:0] e);
    int k;
    @(negedge ref_clk);
    q.push_back(e);
    rx_frame = f;
    rx_valid = 1'b1;
    for (k = 0; k < 5000 && rx_ready !== 1'b1; k++) @(negedge ref_clk);
    @(negedge ref_clk);
    rx_valid = 1'b0;
  endtask
  task automatic settle();
    int k;
    for (k = 0; k < 5000 && q.size() != 0; k++) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] b);
    n_checks++;
    if (a !== b) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, a, b);
    end
  endtask
  task automatic roles(input logic l, input logic t);
    chk({6'h00, is_listener, is_talker}, {6'h00, l, t});
  endtask
  initial begin
    int i;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    send({CMD, 8'h20}, {CMD, 8'h20});
    settle();
    roles(1'b0, 1'b0);
    send({RDY, 8'h80}, {RDY, 8'h81});
    send({RDY, 8'h80}, {RDY, 8'h80});
    send({CMD, 8'h20}, {CMD, 8'h20});
    settle();
    roles(1'b1, 1'b0);
    send({CMD, 8'h40}, {CMD, 8'h40});
    settle();
    roles(1'b0, 1'b1);
    send({RDY, `LD_SAI}, {3'h0, ACC});
    send({3'h0, ACC}, {RDY, `LD_ETO});
    send({RDY, `LD_SST}, {3'h0, `LD_STAT_IDLE});
    send({3'h0, `LD_STAT_IDLE}, {RDY, `LD_ETO});
    for (i = 0; i < 6; i++) id[i] = PFX[47 - 8 * i -: 8];
    id[6] = `LD_ASCII_ZERO + 8'h04;
    id[7] = `LD_ASCII_LOW;
    id[8] = `LD_ASCII_CR;
    id[9] = `LD_ASCII_LF;
    send({RDY, `LD_SDI}, {3'h0, id[0]});
    for (i = 0; i < 9; i++) send({3'h0, id[i]}, {3'h0, id[i + 1]});
    send({3'h0, id[9]}, {RDY, `LD_ETO});
    send({RDY, `LD_SDI}, {3'h0, id[0]});
    send({3'h0, ~id[0]}, {RDY, `LD_ETE});
    send({RDY, `LD_SST}, {3'h0, `LD_STAT_LOOP_ERR});
    send({3'h0, `LD_STAT_LOOP_ERR}, {RDY, `LD_ETO});
    send({CMD, 8'h41}, {CMD, 8'h41});
    settle();
    roles(1'b0, 1'b0);
    // one full record in continuous mode, starting from a cleared pointer
    send({CMD, 8'h20}, {CMD, 8'h20});
    send({CMD, `LD_DCL}, {CMD, `LD_DCL});
    send({CMD, WR}, {CMD, WR});
    send({RDY, `LD_RFC}, {RDY, `LD_RFC});
    for (i = 0; i < 256; i++) begin
      rn = lfsr(rn);
      dat[i] = rn[7:0];
      send({3'h0, rn[7:0]}, {3'h0, rn[7:0]});
    end
    for (i = 0; i < 3000 && loop_medium_model_inst.n_wr < 256; i++) @(negedge ref_clk);
    for (i = 0; i < 256; i++) chk(loop_medium_model_inst.cells[{11'h000, i[7:0]}], dat[i]);
    send({CMD, `LD_UNL}, {CMD, `LD_UNL});
    settle();
    roles(1'b0, 1'b0);
    send({CMD, 8'h40}, {CMD, 8'h40});
    send({CMD, `LD_AAU}, {CMD, `LD_AAU});
    settle();
    roles(1'b0, 1'b0);
    send({CMD, 8'h20}, {CMD, 8'h20});
    send({CMD, `LD_IFC}, {CMD, `LD_IFC});
    settle();
    roles(1'b0, 1'b0);
    send({CMD, `LD_LPD}, {CMD, `LD_LPD});
    settle();
    chk({7'h00, powered_off}, 8'h01);
    power_good_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    power_good_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk({7'h00, powered_off}, 8'h00);
    send({CMD, 8'h40}, {CMD, 8'h40});
    settle();
    roles(1'b0, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
